// *** logic/ff_pkg.sv ***
// shared constants and types of the flat-field correction block
package ff_pkg;
  localparam int PIX_W = 8;
  localparam int TGT_W = 8;
  localparam int GAIN_W = 16;
  localparam int GAIN_FRAC = 12;
  localparam int CAL_LINES = 1024;
  localparam int CAL_SHIFT = 10;
  localparam int NUM_SLOTS = 5;
  localparam int SLOT_W = 3;
  localparam int LCNT_W = 11;
  localparam int OCC_W = 2;
  localparam logic [OCC_W-1:0] OCC_LIMIT = 2'h2;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_TARGET = 8'h04;
  localparam logic [7:0] ADR_CMD = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0c;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SLOT_LSB = 4;
  localparam int CMD_GEN_BIT = 0;
  localparam int CMD_SAVE_BIT = 1;
  localparam int CMD_LOAD_BIT = 2;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_VALID_BIT = 3;
  localparam int ST_REJ_BIT = 4;
  localparam int ST_TGT_LSB = 8;
  localparam int ST_LINES_LSB = 16;
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic [SLOT_W-1:0] SLOT_RST = 3'h0;
  localparam logic [TGT_W-1:0] TARGET_RST = 8'h00;
  localparam logic [GAIN_W-1:0] GAIN_UNITY = 16'h1000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACCUM = 3'b001,
    ST_DIVIDE = 3'b010,
    ST_SAVE = 3'b011,
    ST_LOAD = 3'b100
  } state_e;
  typedef struct packed {
    logic sol;
    logic [PIX_W-1:0] data;
  } pix_s;
endpackage

// *** logic/coef_ram.sv ***
// simple dual-port memory with registered read data
module coef_ram #(
  parameter int W = 16,
  parameter int DEPTH = 4096,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic mclk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [W-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [W-1:0] rd_data_o
);
  // contents are not cleared by reset; validity is tracked by the owner
  logic [W-1:0] mem_q [DEPTH];

  always_ff @(posedge mclk_i)
  begin
    if (wr_en_i)
    begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    rd_data_o <= mem_q[rd_addr_i];
  end
endmodule // coef_ram

// *** logic/skid_pair.sv ***
// two-entry buffer; output taken straight from the head register
module skid_pair #(
  parameter int W = 9
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  logic tail_v_q;
  logic [W-1:0] tail_q;
  logic push;
  logic pop;

  assign in_ready_o = ~tail_v_q;
  assign push = in_valid_i & ~tail_v_q;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      out_valid_o <= 1'b0;
      tail_v_q <= 1'b0;
      out_data_o <= '0;
      tail_q <= '0;
    end
    else if (pop)
    begin
      if (tail_v_q)
      begin
        out_data_o <= tail_q;
        tail_v_q <= 1'b0;
      end
      else if (push)
      begin
        out_data_o <= in_data_i;
      end
      else
      begin
        out_valid_o <= 1'b0;
      end
    end
    else if (push)
    begin
      if (!out_valid_o)
      begin
        out_data_o <= in_data_i;
        out_valid_o <= 1'b1;
      end
      else
      begin
        tail_q <= in_data_i;
        tail_v_q <= 1'b1;
      end
    end
  end
endmodule // skid_pair

// *** logic/flatfield_correct.sv ***
// photo-response flat-field correction with calibration and five saved slots
// Operation
// - correct outgoing pixels only while enable is 1, else pass them unchanged
// - five saved slots 0..4; selector picks the slot for save and load
// - generate target 0 means automatic, 1..255 fixes the target level
// - generate accumulates at least 1024 lines before producing correction values
// - new values go to working memory and are used at once
// - save copies working values into the selected slot, overwriting it
// - working values are lost on reset; only saved slots persist
// - load copies the selected slot into working memory, replacing unsaved values
// - calibration covers the full sensor width, ignoring any region of interest
module flatfield_correct #(
  parameter int LINE_PIXELS = 4096
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pix_valid_i,
  input wire ff_pkg::pix_s pix_i,
  output logic pix_ready_o,
  output logic pix_valid_o,
  output ff_pkg::pix_s pix_o,
  input wire logic pix_ready_i
);
  localparam int IDX_W = $clog2(LINE_PIXELS);
  localparam int ACC_W = ff_pkg::PIX_W + ff_pkg::CAL_SHIFT;
  localparam int NUM_W = ff_pkg::TGT_W + ff_pkg::GAIN_FRAC + ff_pkg::CAL_SHIFT;
  localparam int NV_DEPTH = ff_pkg::NUM_SLOTS * LINE_PIXELS;
  localparam int NV_AW = $clog2(NV_DEPTH);
  localparam int DCNT_W = 6;
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(LINE_PIXELS - 1);
  localparam logic [DCNT_W-1:0] DCNT_LOAD = 6'h01;
  localparam logic [DCNT_W-1:0] DCNT_WRITE = DCNT_W'(NUM_W + 2);
  localparam logic [ff_pkg::LCNT_W-1:0] LINES_DONE = ff_pkg::LCNT_W'(ff_pkg::CAL_LINES);

  ff_pkg::state_e state_q;
  logic en_q;
  logic [ff_pkg::SLOT_W-1:0] slot_q;
  logic [ff_pkg::SLOT_W-1:0] op_slot_q;
  logic [ff_pkg::TGT_W-1:0] target_q;
  logic [ff_pkg::TGT_W-1:0] tgt_lat_q;
  logic [ff_pkg::TGT_W-1:0] max_q;
  logic work_valid_q;
  logic reject_q;
  logic [IDX_W-1:0] idx_q;
  logic [IDX_W-1:0] op_idx_q;
  logic [IDX_W-1:0] copy_idx_q;
  logic copy_v_q;
  logic arm_q;
  logic [ff_pkg::LCNT_W-1:0] lines_q;
  logic [ff_pkg::OCC_W-1:0] occ_q;
  logic s1_v_q;
  ff_pkg::pix_s s1_pix_q;
  logic [IDX_W-1:0] s1_idx_q;
  logic s1_cal_q;
  logic s1_first_q;
  logic [DCNT_W-1:0] dcnt_q;
  logic [ACC_W-1:0] den_q;
  logic [ACC_W-1:0] rem_q;
  logic [NUM_W-1:0] num_q;
  logic [NUM_W-1:0] quo_q;

  logic wb_req;
  logic cmd_wr;
  logic go_gen;
  logic go_save;
  logic go_load;
  logic acc_in;
  logic pop_out;
  logic [IDX_W-1:0] cur_idx;
  logic cal_line_done;
  logic cal_done;
  logic op_done;
  logic [ff_pkg::TGT_W-1:0] tgt_eff;
  logic [NV_AW-1:0] nv_base;
  logic [ACC_W-1:0] acc_rd;
  logic [ACC_W-1:0] acc_sum;
  logic acc_wr;
  logic [ff_pkg::GAIN_W-1:0] work_rd;
  logic [ff_pkg::GAIN_W-1:0] gain;
  logic [ff_pkg::GAIN_W-1:0] gain_sat;
  logic [ff_pkg::GAIN_W-1:0] work_wdata;
  logic work_wr;
  logic [ff_pkg::GAIN_W-1:0] nv_rd;
  logic nv_wr;
  logic [ff_pkg::PIX_W+ff_pkg::GAIN_W-1:0] prod;
  logic [ff_pkg::PIX_W+ff_pkg::GAIN_W-1:0] scaled;
  ff_pkg::pix_s corr;
  logic buf_in_ready;
  logic [ACC_W:0] rem_sh;
  logic open_now;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign cmd_wr = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ff_pkg::ADR_CMD);
  assign open_now = (state_q == ff_pkg::ST_IDLE) | (state_q == ff_pkg::ST_ACCUM);
  assign go_gen = cmd_wr & (state_q == ff_pkg::ST_IDLE) & wb_dat_i[ff_pkg::CMD_GEN_BIT];
  // a slot outside 0..4 makes save and load refuse; an empty working memory makes only save refuse
  assign go_save = cmd_wr & (state_q == ff_pkg::ST_IDLE) & wb_dat_i[ff_pkg::CMD_SAVE_BIT]
                   & ~wb_dat_i[ff_pkg::CMD_GEN_BIT] & work_valid_q
                   & (slot_q < ff_pkg::SLOT_W'(ff_pkg::NUM_SLOTS));
  assign go_load = cmd_wr & (state_q == ff_pkg::ST_IDLE) & wb_dat_i[ff_pkg::CMD_LOAD_BIT]
                   & ~wb_dat_i[ff_pkg::CMD_GEN_BIT] & ~wb_dat_i[ff_pkg::CMD_SAVE_BIT]
                   & (slot_q < ff_pkg::SLOT_W'(ff_pkg::NUM_SLOTS));
  assign acc_in = pix_valid_i & pix_ready_o;
  assign pop_out = pix_valid_o & pix_ready_i;
  assign cur_idx = pix_i.sol ? '0 : idx_q;
  // a line counts only once its last pixel of the full width is in
  assign cal_line_done = s1_v_q & s1_cal_q & (s1_idx_q == IDX_LAST);
  assign cal_done = cal_line_done & (lines_q == LINES_DONE - 1'b1);
  assign op_done = ((state_q == ff_pkg::ST_DIVIDE) & (dcnt_q == DCNT_WRITE) & (op_idx_q == IDX_LAST))
                   | (((state_q == ff_pkg::ST_SAVE) | (state_q == ff_pkg::ST_LOAD))
                   & copy_v_q & (copy_idx_q == IDX_LAST));
  assign tgt_eff = (tgt_lat_q == '0) ? max_q : tgt_lat_q;
  assign nv_base = NV_AW'(op_slot_q) * NV_AW'(LINE_PIXELS);
  assign acc_sum = (s1_first_q ? '0 : acc_rd) + ACC_W'(s1_pix_q.data);
  assign acc_wr = s1_v_q & s1_cal_q;
  assign rem_sh = {rem_q, num_q[NUM_W-1]};
  assign gain_sat = (quo_q[NUM_W-1:ff_pkg::GAIN_W] != '0) ? '1 : quo_q[ff_pkg::GAIN_W-1:0];
  assign work_wr = ((state_q == ff_pkg::ST_DIVIDE) & (dcnt_q == DCNT_WRITE))
                   | ((state_q == ff_pkg::ST_LOAD) & copy_v_q);
  assign work_wdata = (state_q == ff_pkg::ST_LOAD) ? nv_rd : gain_sat;
  assign nv_wr = (state_q == ff_pkg::ST_SAVE) & copy_v_q;
  // no valid working values means unity gain, so a fresh reset never reuses stale memory
  assign gain = work_valid_q ? work_rd : ff_pkg::GAIN_UNITY;
  assign prod = s1_pix_q.data * gain;
  assign scaled = prod >> ff_pkg::GAIN_FRAC;
  always_comb
  begin
    corr.sol = s1_pix_q.sol;
    corr.data = s1_pix_q.data;
    if (en_q)
    begin
      corr.data = (scaled[ff_pkg::PIX_W+ff_pkg::GAIN_W-1:ff_pkg::PIX_W] != '0) ? '1
                  : scaled[ff_pkg::PIX_W-1:0];
    end
  end

  coef_ram #(.W(ACC_W), .DEPTH(LINE_PIXELS)) u_accum (
    .mclk_i(mclk_i),
    .wr_en_i(acc_wr),
    .wr_addr_i(s1_idx_q),
    .wr_data_i(acc_sum),
    .rd_addr_i((state_q == ff_pkg::ST_DIVIDE) ? op_idx_q : cur_idx),
    .rd_data_o(acc_rd)
  );

  coef_ram #(.W(ff_pkg::GAIN_W), .DEPTH(LINE_PIXELS)) u_work (
    .mclk_i(mclk_i),
    .wr_en_i(work_wr),
    .wr_addr_i((state_q == ff_pkg::ST_LOAD) ? copy_idx_q : op_idx_q),
    .wr_data_i(work_wdata),
    .rd_addr_i((state_q == ff_pkg::ST_SAVE) ? op_idx_q : cur_idx),
    .rd_data_o(work_rd)
  );

  coef_ram #(.W(ff_pkg::GAIN_W), .DEPTH(NV_DEPTH)) u_slots (
    .mclk_i(mclk_i),
    .wr_en_i(nv_wr),
    .wr_addr_i(nv_base + NV_AW'(copy_idx_q)),
    .wr_data_i(work_rd),
    .rd_addr_i(nv_base + NV_AW'(op_idx_q)),
    .rd_data_o(nv_rd)
  );

  skid_pair #(.W($bits(ff_pkg::pix_s))) u_out (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(s1_v_q),
    .in_data_i(corr),
    .in_ready_o(buf_in_ready),
    .out_valid_o(pix_valid_o),
    .out_data_o(pix_o),
    .out_ready_i(pix_ready_i)
  );

  // wishbone slave: one-cycle registered answer, unmapped reads return zero
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      en_q <= ff_pkg::CTRL_EN_RST;
      slot_q <= ff_pkg::SLOT_RST;
      target_q <= ff_pkg::TARGET_RST;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= '0;
      if (wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ff_pkg::ADR_CTRL))
      begin
        en_q <= wb_dat_i[ff_pkg::CTRL_EN_BIT];
        slot_q <= wb_dat_i[ff_pkg::CTRL_SLOT_LSB +: ff_pkg::SLOT_W];
      end
      if (wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ff_pkg::ADR_TARGET))
      begin
        target_q <= wb_dat_i[ff_pkg::TGT_W-1:0];
      end
      if (wb_req & ~wb_we_i)
      begin
        case (wb_adr_i)
          ff_pkg::ADR_CTRL:
          begin
            wb_dat_o[ff_pkg::CTRL_EN_BIT] <= en_q;
            wb_dat_o[ff_pkg::CTRL_SLOT_LSB +: ff_pkg::SLOT_W] <= slot_q;
          end
          ff_pkg::ADR_TARGET: wb_dat_o[ff_pkg::TGT_W-1:0] <= target_q;
          ff_pkg::ADR_STATUS:
          begin
            wb_dat_o[ff_pkg::ST_STATE_LSB +: 3] <= state_q;
            wb_dat_o[ff_pkg::ST_VALID_BIT] <= work_valid_q;
            wb_dat_o[ff_pkg::ST_REJ_BIT] <= reject_q;
            wb_dat_o[ff_pkg::ST_TGT_LSB +: ff_pkg::TGT_W] <= tgt_eff;
            wb_dat_o[ff_pkg::ST_LINES_LSB +: ff_pkg::LCNT_W] <= lines_q;
          end
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  // operation sequencer
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= ff_pkg::ST_IDLE;
      work_valid_q <= 1'b0;
      reject_q <= 1'b0;
      op_slot_q <= '0;
      tgt_lat_q <= '0;
    end
    else
    begin
      if (cmd_wr)
      begin
        reject_q <= ~(go_gen | go_save | go_load);
      end
      case (state_q)
        ff_pkg::ST_IDLE:
        begin
          op_slot_q <= slot_q;
          if (go_gen)
          begin
            tgt_lat_q <= target_q;
            state_q <= ff_pkg::ST_ACCUM;
          end
          else if (go_save)
          begin
            state_q <= ff_pkg::ST_SAVE;
          end
          else if (go_load)
          begin
            state_q <= ff_pkg::ST_LOAD;
          end
        end
        ff_pkg::ST_ACCUM:
        begin
          if (cal_done)
          begin
            state_q <= ff_pkg::ST_DIVIDE;
          end
        end
        ff_pkg::ST_DIVIDE, ff_pkg::ST_SAVE, ff_pkg::ST_LOAD:
        begin
          if (op_done)
          begin
            state_q <= ff_pkg::ST_IDLE;
            if (state_q != ff_pkg::ST_SAVE)
            begin
              work_valid_q <= 1'b1;
            end
          end
        end
        default: state_q <= ff_pkg::ST_IDLE;
      endcase
    end
  end

  // input acceptance; occupancy covers stage one plus the buffer so no word is lost
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      occ_q <= '0;
      pix_ready_o <= 1'b0;
      idx_q <= '0;
    end
    else
    begin
      occ_q <= occ_q + ff_pkg::OCC_W'(acc_in) - ff_pkg::OCC_W'(pop_out);
      pix_ready_o <= ((occ_q + ff_pkg::OCC_W'(acc_in) - ff_pkg::OCC_W'(pop_out)) < ff_pkg::OCC_LIMIT)
                     & ((open_now & ~go_save & ~go_load & ~cal_done) | op_done);
      if (acc_in)
      begin
        idx_q <= (cur_idx == IDX_LAST) ? '0 : cur_idx + 1'b1;
      end
    end
  end

  // stage one: memory reads land here; calibration starts at a line start
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s1_v_q <= 1'b0;
      s1_pix_q <= '0;
      s1_idx_q <= '0;
      s1_cal_q <= 1'b0;
      s1_first_q <= 1'b0;
      arm_q <= 1'b0;
      lines_q <= '0;
      max_q <= '0;
    end
    else
    begin
      s1_v_q <= acc_in;
      s1_pix_q <= pix_i;
      s1_idx_q <= cur_idx;
      s1_first_q <= (lines_q == '0) & ~cal_line_done; // a line finishing this cycle already counts
      s1_cal_q <= acc_in & (state_q == ff_pkg::ST_ACCUM) & (arm_q | pix_i.sol) & ~cal_done;
      if (go_gen)
      begin
        arm_q <= 1'b0;
        lines_q <= '0;
        max_q <= '0;
      end
      else
      begin
        if (acc_in & pix_i.sol & (state_q == ff_pkg::ST_ACCUM))
        begin
          arm_q <= 1'b1;
        end
        if (cal_line_done)
        begin
          lines_q <= lines_q + 1'b1;
        end
        if (acc_wr & (lines_q == LINES_DONE - 1'b1) & (acc_sum[ACC_W-1 -: ff_pkg::TGT_W] > max_q))
        begin
          max_q <= acc_sum[ACC_W-1 -: ff_pkg::TGT_W];
        end
      end
    end
  end

  // per-pixel divider: gain = target * 2^(frac+10) / sum of 1024 lines
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      op_idx_q <= '0;
      dcnt_q <= '0;
      den_q <= '0;
      rem_q <= '0;
      num_q <= '0;
      quo_q <= '0;
      copy_v_q <= 1'b0;
      copy_idx_q <= '0;
    end
    else
    begin
      copy_v_q <= 1'b0;
      copy_idx_q <= op_idx_q;
      if (state_q == ff_pkg::ST_DIVIDE)
      begin
        dcnt_q <= (dcnt_q == DCNT_WRITE) ? '0 : dcnt_q + 1'b1;
        if (dcnt_q == DCNT_LOAD)
        begin
          den_q <= acc_rd;
          rem_q <= '0;
          num_q <= {tgt_eff, (NUM_W-ff_pkg::TGT_W)'(0)};
        end
        else if (dcnt_q > DCNT_LOAD && dcnt_q < DCNT_WRITE)
        begin
          num_q <= num_q << 1;
          if (rem_sh >= {1'b0, den_q})
          begin
            rem_q <= ACC_W'(rem_sh - {1'b0, den_q});
            quo_q <= {quo_q[NUM_W-2:0], 1'b1};
          end
          else
          begin
            rem_q <= rem_sh[ACC_W-1:0];
            quo_q <= {quo_q[NUM_W-2:0], 1'b0};
          end
        end
        else if (dcnt_q == DCNT_WRITE)
        begin
          op_idx_q <= op_idx_q + 1'b1;
        end
      end
      else if ((state_q == ff_pkg::ST_SAVE) | (state_q == ff_pkg::ST_LOAD))
      begin
        copy_v_q <= ~(copy_v_q & (copy_idx_q == IDX_LAST)) & ~(op_idx_q == '0 & copy_v_q);
        if (!(copy_v_q & (copy_idx_q == IDX_LAST)))
        begin
          op_idx_q <= (op_idx_q == IDX_LAST) ? op_idx_q : op_idx_q + 1'b1;
        end
      end
      else
      begin
        op_idx_q <= '0;
        dcnt_q <= '0;
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  bypass_when_off_a: assert property (s1_v_q && !en_q |-> corr == s1_pix_q)
    else $error("pixel altered while correction is off");
  slot_in_range_a: assert property (nv_wr |-> op_slot_q < ff_pkg::SLOT_W'(ff_pkg::NUM_SLOTS))
    else $error("slot access outside 0..4");
  fixed_target_a: assert property (state_q == ff_pkg::ST_DIVIDE && dcnt_q == DCNT_LOAD && tgt_lat_q != '0
                                   |=> num_q[NUM_W-1 -: ff_pkg::TGT_W] == tgt_lat_q)
    else $error("fixed target not used");
  cal_line_count_a: assert property ($rose(state_q == ff_pkg::ST_DIVIDE) |-> lines_q == LINES_DONE)
    else $error("divide started before 1024 lines");
  gen_activates_a: assert property (state_q == ff_pkg::ST_DIVIDE && op_done |=> work_valid_q && state_q == ff_pkg::ST_IDLE)
    else $error("generated values not activated");
  save_target_a: assert property (nv_wr |-> $past(state_q) == ff_pkg::ST_SAVE && copy_idx_q == $past(op_idx_q))
    else $error("slot write outside save");
  reset_forgets_a: assert property ($past(sys_rst_i) |-> !work_valid_q)
    else $error("working values survived reset");
  load_copies_a: assert property (state_q == ff_pkg::ST_LOAD && copy_v_q |-> work_wr && work_wdata == nv_rd)
    else $error("load did not copy slot data");
  full_width_a: assert property (lines_q != $past(lines_q) && state_q == ff_pkg::ST_ACCUM
                                 && lines_q != '0 |-> $past(s1_idx_q) == IDX_LAST)
    else $error("line counted before full width");
  unity_gain_a: assert property (s1_v_q && en_q && !work_valid_q |-> corr.data == s1_pix_q.data)
    else $error("gain applied without working values");
  no_overflow_a: assert property (s1_v_q |-> buf_in_ready)
    else $error("output buffer overflow");

  gen_done_c: cover property (state_q == ff_pkg::ST_DIVIDE && op_done);
  save_done_c: cover property (state_q == ff_pkg::ST_SAVE && op_done);
  load_done_c: cover property (state_q == ff_pkg::ST_LOAD && op_done);
  stall_full_c: cover property (pix_valid_o && !pix_ready_i && !buf_in_ready);
endmodule // flatfield_correct

// *** tb/sensor_stream_model.sv ***
// free-running line source and stalling receiver around the correction block
module sensor_stream_model #(
  parameter int LINE_PIXELS = 8
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic stall_i,
  input wire logic hold_i,
  input wire logic pix_ready_i,
  output logic pix_valid_o,
  output ff_pkg::pix_s pix_o,
  output logic sink_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] idx_q;
  logic [2:0] tick_q;
  // valid never drops once raised, so a pixel is always held until taken
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      idx_q <= 16'h0;
      pix_valid_o <= 1'b0;
    end
    else
    begin
      pix_valid_o <= 1'b1;
      if (pix_valid_o && pix_ready_i)
        idx_q <= (idx_q == 16'(LINE_PIXELS - 1)) ? 16'h0 : idx_q + 16'h1;
    end
  end
  // one fixed power-of-two level per pixel keeps every average and gain exact
  assign pix_o.sol = (idx_q == 16'h0);
  // brightest pixel sits inside the recommended scene band; dimmer ones exercise large gains
  assign pix_o.data = 8'h10 << idx_q[1:0];
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tick_q <= 3'h0;
      sink_ready_o <= 1'b0;
    end
    else
    begin
      tick_q <= tick_q + 3'h1;
      sink_ready_o <= !(hold_i || (stall_i && tick_q[2]));
    end
  end
endmodule // sensor_stream_model

// *** tb/photo_response_flatfield_correction_bench.sv ***
// self-checking bench for the flat-field correction block
module photo_response_flatfield_correction_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LP = 8;
  logic mclk_i, sys_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic pix_valid_i, pix_ready_o, pix_valid_o, pix_ready_i, stall, hold;
  ff_pkg::pix_s pix_i, pix_o;
  int fail_count = 0;
  int comparisons = 0;

  flatfield_correct #(.LINE_PIXELS(LP)) dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pix_valid_i(pix_valid_i), .pix_i(pix_i),
    .pix_ready_o(pix_ready_o), .pix_valid_o(pix_valid_o), .pix_o(pix_o), .pix_ready_i(pix_ready_i));
  sensor_stream_model #(.LINE_PIXELS(LP)) stream_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .stall_i(stall),
    .hold_i(hold), .pix_ready_i(pix_ready_o), .pix_valid_o(pix_valid_i), .pix_o(pix_i),
    .sink_ready_o(pix_ready_i));

  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    @(posedge mclk_i);
    while (wb_ack_o !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge mclk_i);
    end
    if (n >= 50)
      fail_count++;
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(r & mask, exp);
  endtask

  // polling rather than a fixed wait: calibration length depends on the stall pattern
  task automatic wait_idle();
    logic [31:0] r;
    int n;
    n = 0;
    r = 32'h7;
    while (r[2:0] !== 3'h0 && n < 20000)
    begin
      wb(1'b0, ff_pkg::ADR_STATUS, 32'h0, r);
      n++;
    end
    if (n >= 20000)
      fail_count++;
  endtask

  // lvl 0 expects the raw level of each pixel, else every pixel at lvl
  task automatic watch(input int cnt, input logic [7:0] lvl);
    int idx;
    int n;
    int k;
    idx = -1;
    n = 0;
    k = 0;
    repeat (10) @(posedge mclk_i);
    while (n < cnt && k < 2000)
    begin
      @(negedge mclk_i);
      k++;
      if (pix_valid_o === 1'b1 && pix_ready_i === 1'b1)
      begin
        if (pix_o.sol === 1'b1)
          idx = 0;
        if (idx >= 0)
        begin
          chk({24'h0, pix_o.data}, {24'h0, (lvl == 8'h0) ? 8'(8'h10 << (idx % 4)) : lvl});
          idx++;
          n++;
        end
      end
    end
    if (n < cnt)
      fail_count++;
  endtask

  task automatic t_reset_state();
    rd_chk(ff_pkg::ADR_CTRL, 32'h0, 32'h71);
    rd_chk(ff_pkg::ADR_STATUS, 32'h0, 32'h1f);
    wr(8'h20, 32'hff);
    rd_chk(8'h20, 32'h0, 32'hffffffff);
  endtask

  task automatic t_pass();
    wr(ff_pkg::ADR_CTRL, 32'h0);
    watch(16, 8'h0);
    @(posedge mclk_i);
    hold <= 1'b1;
    repeat (12) @(posedge mclk_i);
    @(negedge mclk_i);
    chk({31'h0, pix_ready_o}, 32'h0);
    chk({31'h0, pix_valid_o}, 32'h1);
    @(posedge mclk_i);
    hold <= 1'b0;
    wr(ff_pkg::ADR_CTRL, 32'h1);
    watch(16, 8'h0);
  endtask

  task automatic gen(input logic [7:0] tgt, input logic [7:0] eff);
    wr(ff_pkg::ADR_TARGET, {24'h0, tgt});
    wr(ff_pkg::ADR_CMD, 32'h1);
    wait_idle();
    rd_chk(ff_pkg::ADR_STATUS, 32'h0400_0008 | ({24'h0, eff} << 8), 32'h07ff_ff1f);
    watch(24, eff);
  endtask

  task automatic t_save();
    wr(ff_pkg::ADR_CTRL, 32'h41);
    wr(ff_pkg::ADR_CMD, 32'h2);
    wait_idle();
    rd_chk(ff_pkg::ADR_STATUS, 32'h8, 32'h18);
    wr(ff_pkg::ADR_CTRL, 32'h51);
    wr(ff_pkg::ADR_CMD, 32'h2);
    rd_chk(ff_pkg::ADR_STATUS, 32'h18, 32'h18);
    wr(ff_pkg::ADR_CTRL, 32'h41);
  endtask

  task automatic t_load();
    wr(ff_pkg::ADR_CMD, 32'h4);
    wait_idle();
    watch(16, 8'h40);
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rd_chk(ff_pkg::ADR_STATUS, 32'h0, 32'h8);
    wr(ff_pkg::ADR_CTRL, 32'h41);
    watch(16, 8'h0);
    wr(ff_pkg::ADR_CMD, 32'h4);
    wait_idle();
    watch(16, 8'h40);
  endtask

  initial
  begin
    sys_rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    stall = 1'b1;
    hold = 1'b0;
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_reset_state();
    t_pass();
    gen(8'h40, 8'h40);
    t_save();
    gen(8'h00, 8'h80); // regenerate with target 0, the automatic level from the brightest pixel
    t_load();
    end_sim();
  end

  // two calibrations at three-eighths throughput dominate; this leaves ample margin
  initial
  begin
    repeat (95000) @(posedge mclk_i);
    fail_count++;
    end_sim();
  end
endmodule // photo_response_flatfield_correction_bench
